// [design/rail_seq_regs.vh]
// Register map, field positions, reset values and timing for the rail sequencer.
// Included by the sequencer top; holds definitions only.
`ifndef RAIL_SEQ_REGS_VH
`define RAIL_SEQ_REGS_VH

// Register offsets (8-bit pointer space)
`define OFS_SECOND_LINEAR_VOLTAGE_CODE  8'h0b
`define OFS_FIRST_BUCK_SEQUENCE_DELAYS  8'h0c
`define OFS_SECOND_BUCK_SEQUENCE_DELAYS 8'h0d
`define OFS_FIRST_LINEAR_SEQUENCE_DELAYS 8'h0e
`define OFS_RAIL_CONTROL                8'h20
`define OFS_STEP_CONFIG                 8'h21
`define OFS_RAIL_STATUS                 8'h22

// Reset values
`define RST_SECOND_LINEAR_VOLTAGE_CODE  8'h02
`define RST_SEQUENCE_DELAYS             8'h00
`define RST_RAIL_CONTROL                8'h00
`define RST_STEP_CONFIG                 8'h00

// Delay register fields: on delay in low nibble, off delay in high nibble
`define FLD_ON_DELAY_LSB   0
`define FLD_OFF_DELAY_LSB  4
`define FLD_DELAY_WIDTH    4

// Rail control fields: per rail i, enable bit at 2*i, pin follow at 2*i+1
`define FLD_ENABLE_BIT     0
`define FLD_PIN_FOLLOW_BIT 1

// Step config fields
`define FLD_ON_STEP_SEL    0
`define FLD_OFF_STEP_SEL   1

// Second linear regulator voltage code decode
`define VSET_WIDTH         5
`define VSET_BASE_MV       12'h0320
`define VSET_STEP_MV       12'h0064
`define VSET_MAX_CODE      5'h19

// Timing: one delay step in microseconds, clock rate in MHz
`define SEQ_STEP_US        500
`define SEQ_CLK_MHZ        20

// Serial bus target address (7 bits)
`define SERIAL_TARGET_ADDR 7'h60

`endif

// [design/rail_sequence_delays.v]
// Rail sequencer: serial register target, enable pin edge timing and
// per-rail startup and shutdown delay counters for three rails.
// Assumes scl, sda_in and enable_pin are already synchronous to clk, and that
// the bus clock is at most a few percent of clk so every edge is seen.
//
// Function
// - The second linear regulator code maps linearly from 0.8 V in 100 mV steps to 3.3 V at 0x19, with 0x1A-0x1F reserved.
// - On an enable pin rise the first buck turns on after its 4-bit on code times 0.5 ms.
// - On an enable pin fall the first buck turns off after its 4-bit off code times 0.5 ms.
// - On an enable pin rise the second buck turns on after its own 4-bit on code times 0.5 ms.
// - On an enable pin fall the second buck turns off after its own 4-bit off code times 0.5 ms.
// - On an enable pin rise the first linear regulator turns on after its own 4-bit on code times 0.5 ms.
// - On an enable pin fall the first linear regulator turns off after its own 4-bit off code times 0.5 ms.
// - The startup step select bit doubles every on delay step to 1 ms.
// - The shutdown step select bit doubles every off delay step to 1 ms.
// - A rail follows the pin sequence only when its pin follow bit is set, else only its enable bit rules.
`timescale 1ns/10ps
`include "rail_seq_regs.vh"

module rail_sequence_delays #(
	parameter STEP_CYCLES = `SEQ_STEP_US * `SEQ_CLK_MHZ,
	parameter TICK_WIDTH  = 14,
	parameter [6:0] TARGET_ADDR = `SERIAL_TARGET_ADDR
) (
	input  wire        clk,
	input  wire        resetn,
	input  wire        scl,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	input  wire        enable_pin,
	output reg         first_buck_on,
	output reg         second_buck_on,
	output reg         first_linear_on,
	output reg  [4:0]  second_linear_voltage_code,
	output reg  [11:0] second_linear_millivolts,
	output reg         second_linear_code_reserved
);

	// Last prescaler count, cut to the counter width on purpose
	localparam [31:0]           STEP_LAST = STEP_CYCLES - 1;
	localparam [TICK_WIDTH-1:0] TICK_LAST = STEP_LAST[TICK_WIDTH-1:0];

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_ADDR = 3'h1;
	localparam [2:0] S_ACK  = 3'h2;
	localparam [2:0] S_RX   = 3'h3;
	localparam [2:0] S_TX   = 3'h4;
	localparam [2:0] S_MACK = 3'h5;

	reg  [7:0] voltage_reg;
	reg  [7:0] delay_reg [0:2];
	reg  [7:0] rail_control;
	reg  [7:0] step_config;
	wire [2:0] seq_state;
	reg        en_prev;
	reg  [TICK_WIDTH-1:0] tick_cnt;
	reg        tick;
	reg        scl_prev;
	reg        sda_prev;
	reg  [2:0] state;
	reg  [3:0] bit_cnt;
	reg  [7:0] shift;
	reg  [7:0] ptr;
	reg        have_ptr;
	reg        is_read;

	wire       pin_rise = enable_pin & ~en_prev;
	wire       pin_fall = ~enable_pin & en_prev;
	wire       start_cond = scl & scl_prev & sda_prev & ~sda_in;
	wire       stop_cond = scl & scl_prev & ~sda_prev & sda_in;
	wire       scl_rise = scl & ~scl_prev;
	wire       scl_fall = ~scl & scl_prev;
	wire [2:0] rail_now = {first_linear_on, second_buck_on, first_buck_on};

	// Register read mux; unmapped offsets read as zero
	function [7:0] reg_read;
		input [7:0] a;
		begin
			case (a)
			`OFS_SECOND_LINEAR_VOLTAGE_CODE:   reg_read = voltage_reg;
			`OFS_FIRST_BUCK_SEQUENCE_DELAYS:   reg_read = delay_reg[0];
			`OFS_SECOND_BUCK_SEQUENCE_DELAYS:  reg_read = delay_reg[1];
			`OFS_FIRST_LINEAR_SEQUENCE_DELAYS: reg_read = delay_reg[2];
			`OFS_RAIL_CONTROL:                 reg_read = rail_control;
			`OFS_STEP_CONFIG:                  reg_read = step_config;
			`OFS_RAIL_STATUS:                  reg_read = {1'b0, en_prev, seq_state, rail_now};
			default:                           reg_read = 8'h00;
			endcase
		end
	endfunction

	// Byte to send next on a read, looked up once for load and first bit
	wire [7:0] read_data = reg_read(ptr);

	////////////////////////////////////////////////////////////////////////////
	// Serial target: start, address, pointer, auto-incremented data bytes
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_prev     <= 1'b1;
			sda_prev     <= 1'b1;
			state        <= S_IDLE;
			bit_cnt      <= 4'h0;
			shift        <= 8'h00;
			ptr          <= 8'h00;
			have_ptr     <= 1'b0;
			is_read      <= 1'b0;
			sda_out      <= 1'b0;
			sda_oe       <= 1'b0;
			voltage_reg  <= `RST_SECOND_LINEAR_VOLTAGE_CODE;
			delay_reg[0] <= `RST_SEQUENCE_DELAYS;
			delay_reg[1] <= `RST_SEQUENCE_DELAYS;
			delay_reg[2] <= `RST_SEQUENCE_DELAYS;
			rail_control <= `RST_RAIL_CONTROL;
			step_config  <= `RST_STEP_CONFIG;
		end else begin
			scl_prev <= scl;
			sda_prev <= sda_in;
			if (start_cond) begin
				// Repeated start keeps the pointer for a following read
				state    <= S_ADDR;
				bit_cnt  <= 4'h0;
				have_ptr <= 1'b0;
				sda_oe   <= 1'b0;
			end else if (stop_cond) begin
				state  <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
				S_ADDR, S_RX: begin
					shift   <= {shift[6:0], sda_in};
					bit_cnt <= bit_cnt + 4'h1;
				end
				S_MACK: begin
					if (sda_in)
						state <= S_IDLE; // Not acknowledged: read ends
				end
				default: begin
				end
				endcase
			end else if (scl_fall) begin
				case (state)
				S_ADDR: begin
					if (bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						if (shift[7:1] == TARGET_ADDR) begin
							is_read <= shift[0];
							sda_oe  <= 1'b1;
							state   <= S_ACK;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_RX: begin
					if (bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						sda_oe  <= 1'b1;
						state   <= S_ACK;
						if (!have_ptr) begin
							ptr      <= shift;
							have_ptr <= 1'b1;
						end else begin
							ptr <= ptr + 8'h01;
							case (ptr)
							`OFS_SECOND_LINEAR_VOLTAGE_CODE:   voltage_reg  <= shift;
							`OFS_FIRST_BUCK_SEQUENCE_DELAYS:   delay_reg[0] <= shift;
							`OFS_SECOND_BUCK_SEQUENCE_DELAYS:  delay_reg[1] <= shift;
							`OFS_FIRST_LINEAR_SEQUENCE_DELAYS: delay_reg[2] <= shift;
							`OFS_RAIL_CONTROL:                 rail_control <= shift;
							`OFS_STEP_CONFIG:                  step_config  <= shift;
							default: begin
							end
							endcase
						end
					end
				end
				S_ACK, S_MACK: begin
					if (is_read) begin
						// Load next byte and drive its first bit
						shift   <= read_data;
						ptr     <= ptr + 8'h01;
						sda_oe  <= ~read_data[7];
						bit_cnt <= 4'h0;
						state   <= S_TX;
					end else begin
						sda_oe <= 1'b0;
						state  <= S_RX;
					end
				end
				S_TX: begin
					if (bit_cnt == 4'h7) begin
						sda_oe <= 1'b0; // Release for the controller's answer
						state  <= S_MACK;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
						shift   <= {shift[6:0], 1'b0};
						sda_oe  <= ~shift[6];
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared step tick; restarted on each pin edge so every delay is exact
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_prev  <= 1'b0;
			tick_cnt <= {TICK_WIDTH{1'b0}};
			tick     <= 1'b0;
		end else begin
			en_prev <= enable_pin;
			if (pin_rise | pin_fall) begin
				tick_cnt <= {TICK_WIDTH{1'b0}};
				tick     <= 1'b0;
			end else if (tick_cnt == TICK_LAST) begin
				tick_cnt <= {TICK_WIDTH{1'b0}};
				tick     <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + {{(TICK_WIDTH-1){1'b0}}, 1'b1};
				tick     <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-rail delay counters: rail 0 first buck, 1 second buck, 2 first linear
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : rail
			reg  [4:0] cnt;
			reg        pending;
			reg        seq_on;
			wire [3:0] on_code  = delay_reg[i][`FLD_ON_DELAY_LSB +: `FLD_DELAY_WIDTH];
			wire [3:0] off_code = delay_reg[i][`FLD_OFF_DELAY_LSB +: `FLD_DELAY_WIDTH];
			// Doubled step counts two half-millisecond ticks per code step
			wire [4:0] on_load  = step_config[`FLD_ON_STEP_SEL] ? {on_code, 1'b0} : {1'b0, on_code};
			wire [4:0] off_load = step_config[`FLD_OFF_STEP_SEL] ? {off_code, 1'b0} : {1'b0, off_code};

			// One driver per rail state bit; the status word gathers them
			assign seq_state[i] = seq_on;

			// Load on each edge; a new edge replaces any pending action
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					cnt     <= 5'h00;
					pending <= 1'b0;
					seq_on  <= 1'b0;
				end else if (pin_rise) begin
					cnt     <= on_load;
					pending <= (on_load != 5'h00);
					seq_on  <= (on_load == 5'h00) | seq_on;
				end else if (pin_fall) begin
					cnt     <= off_load;
					pending <= (off_load != 5'h00);
					seq_on  <= (off_load != 5'h00) & seq_on;
				end else if (pending && tick) begin
					cnt <= cnt - 5'h01;
					if (cnt == 5'h01) begin
						pending <= 1'b0;
						seq_on  <= en_prev;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Rail outputs: pin sequence gated in only where the follow bit is set
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first_buck_on   <= 1'b0;
			second_buck_on  <= 1'b0;
			first_linear_on <= 1'b0;
		end else begin
			first_buck_on   <= rail_control[`FLD_ENABLE_BIT] &
			                   (~rail_control[`FLD_PIN_FOLLOW_BIT] | seq_state[0]);
			second_buck_on  <= rail_control[2 + `FLD_ENABLE_BIT] &
			                   (~rail_control[2 + `FLD_PIN_FOLLOW_BIT] | seq_state[1]);
			first_linear_on <= rail_control[4 + `FLD_ENABLE_BIT] &
			                   (~rail_control[4 + `FLD_PIN_FOLLOW_BIT] | seq_state[2]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Voltage code decode, linear from the base in fixed steps
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			second_linear_voltage_code  <= 5'h00;
			second_linear_millivolts    <= 12'h0000;
			second_linear_code_reserved <= 1'b0;
		end else begin
			second_linear_voltage_code  <= voltage_reg[`VSET_WIDTH-1:0];
			second_linear_millivolts    <= `VSET_BASE_MV +
			                               `VSET_STEP_MV * {7'h00, voltage_reg[`VSET_WIDTH-1:0]};
			second_linear_code_reserved <= (voltage_reg[`VSET_WIDTH-1:0] > `VSET_MAX_CODE);
		end
	end

endmodule

// [test/rail_seq_assertions.sv]
// Checker on the rail sequencer ports: bus data timing, voltage decode, rail causes.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
module rail_seq_assertions (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        scl,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        enable_pin,
	input wire logic        first_buck_on,
	input wire logic        second_buck_on,
	input wire logic        first_linear_on,
	input wire logic [4:0]  second_linear_voltage_code,
	input wire logic [11:0] second_linear_millivolts,
	input wire logic        second_linear_code_reserved
);
	logic [1:0] settle;
	// Decode outputs lag reset release, so wait for them
	always @(posedge clk or negedge resetn)
		if (!resetn)
			settle <= 2'h0;
		else if (settle != 2'h3)
			settle <= settle + 2'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	a_pull_only: assert property (sda_out == 1'b0) else $error("data driven high");
	a_mv_decode: assert property (settle == 2'h3 |->
		second_linear_millivolts == 12'h0320 + 12'h0064 * second_linear_voltage_code) else $error("bad millivolts");
	a_reserved_flag: assert property (settle == 2'h3 |->
		second_linear_code_reserved == (second_linear_voltage_code > 5'h19)) else $error("bad reserved flag");
	a_data_scl_low: assert property ($changed(sda_oe) |-> !scl) else $error("data moved with scl high");
	a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*3]) else $error("ack too short");
	// A rail moves only if the pin stood at the new level two cycles back, or during a bus ack
	a_buck_on_cause: assert property ($rose(first_buck_on) |-> sda_oe || $past(enable_pin, 2))
		else $error("first buck rose unprompted");
	a_buck_off_cause: assert property ($fell(first_buck_on) |-> sda_oe || !$past(enable_pin, 2))
		else $error("first buck fell unprompted");
	a_buck2_on_cause: assert property ($rose(second_buck_on) |-> sda_oe || $past(enable_pin, 2))
		else $error("second buck rose unprompted");
	a_buck2_off_cause: assert property ($fell(second_buck_on) |-> sda_oe || !$past(enable_pin, 2))
		else $error("second buck fell unprompted");
	a_linear_on_cause: assert property ($rose(first_linear_on) |-> sda_oe || $past(enable_pin, 2))
		else $error("linear rose unprompted");
	a_linear_off_cause: assert property ($fell(first_linear_on) |-> sda_oe || !$past(enable_pin, 2))
		else $error("linear fell unprompted");
endmodule
bind rail_sequence_delays rail_seq_assertions i_rail_seq_assertions (.clk(clk), .resetn(resetn), .scl(scl),
	.sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin), .first_buck_on(first_buck_on),
	.second_buck_on(second_buck_on), .first_linear_on(first_linear_on),
	.second_linear_voltage_code(second_linear_voltage_code),
	.second_linear_millivolts(second_linear_millivolts),
	.second_linear_code_reserved(second_linear_code_reserved));

// [test/serial_host.sv]
// Host model on the serial register bus: start, stop, register write and read.
// Assumes the bench builds the pulled-up data wire from both pull-downs.
`timescale 1ns/10ps
module serial_host #(
	parameter [6:0] ADDR = 7'h60
) (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Five clocks a half period, margin over the four the target needs
	task half;
		repeat (5) @(negedge clk);
	endtask
	// Data only moves while the clock is low
	task put(input logic b);
		scl = 1'b0;
		half;
		sda_low = !b;
		half;
		scl = 1'b1;
		half;
	endtask
	task get(output logic b);
		put(1'b1);
		b = sda;
	endtask
	task start;
		put(1'b1);
		sda_low = 1'b1;
		half;
	endtask
	task stop;
		put(1'b0);
		sda_low = 1'b0;
		half;
	endtask
	task send(input [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--)
			put(v[i]);
		get(ack);
		ack = !ack;
	endtask
	task write_reg(input [6:0] a, input [7:0] p, input [7:0] d, output [2:0] acks);
		start;
		send({a, 1'b0}, acks[2]);
		send(p, acks[1]);
		send(d, acks[0]);
		stop;
	endtask
	// Last byte is refused so the target lets go of the wire
	task read_reg(input [7:0] p, output [7:0] d);
		logic ack;
		start;
		send({ADDR, 1'b0}, ack);
		send(p, ack);
		start;
		send({ADDR, 1'b1}, ack);
		for (int i = 7; i >= 0; i--)
			get(d[i]);
		put(1'b1);
		stop;
	endtask
endmodule

// [test/testbench.sv]
// Testbench for the rail sequencer: register map, voltage decode, pin delays.
// Assumes the host model on the bus and a 50 ns clock; step shortened to 20 clocks.
`timescale 1ns/10ps
module testbench;
	localparam int S = 20;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        enable_pin = 1'b0;
	wire         scl, sda_low, sda_out, sda_oe, sda;
	wire         first_buck_on, second_buck_on, first_linear_on;
	wire  [4:0]  second_linear_voltage_code;
	wire  [11:0] second_linear_millivolts;
	wire         second_linear_code_reserved;
	int          failures = 0;
	int          checks_done = 0;
	int          t[3];
	logic [7:0]  rd;
	logic [2:0]  acks;
	// Pulled-up open-drain data wire
	assign sda = !(sda_low || sda_oe);
	always #25 clk = !clk;
	rail_sequence_delays #(.STEP_CYCLES(S)) i_rail_sequence_delays (.clk(clk), .resetn(resetn), .scl(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
		.first_buck_on(first_buck_on), .second_buck_on(second_buck_on), .first_linear_on(first_linear_on),
		.second_linear_voltage_code(second_linear_voltage_code),
		.second_linear_millivolts(second_linear_millivolts),
		.second_linear_code_reserved(second_linear_code_reserved));
	serial_host i_serial_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	////////////////////////////////////////////////////////////////
	task check(input [31:0] seen, input [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task write(input [7:0] p, input [7:0] d);
		i_serial_host.write_reg(7'h60, p, d, acks);
		check(acks, 3'h7);
	endtask
	// Moves the pin, notes the cycle each rail first reaches the new level
	task measure(input logic lvl);
		t = '{-1, -1, -1};
		@(negedge clk);
		enable_pin = lvl;
		@(posedge clk);
		for (int i = 0; i < 700; i++) begin
			@(negedge clk);
			if (t[0] < 0 && first_buck_on === lvl) t[0] = i;
			if (t[1] < 0 && second_buck_on === lvl) t[1] = i;
			if (t[2] < 0 && first_linear_on === lvl) t[2] = i;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task test_reset;
		for (int i = 0; i < 4; i++) begin
			i_serial_host.read_reg(8'h0b + i, rd);
			check(rd, i == 0 ? 8'h02 : 8'h00);
		end
		i_serial_host.read_reg(8'h30, rd);
		check(rd, 8'h00);
		check(second_linear_millivolts, 12'h03e8);
	endtask
	task test_vset;
		logic [4:0] c[4] = '{5'h00, 5'h19, 5'h1a, 5'h1f};
		foreach (c[i]) begin
			write(8'h0b, {3'h0, c[i]});
			repeat (3) @(negedge clk);
			check(second_linear_voltage_code, c[i]);
			check(second_linear_millivolts, 12'h0320 + 12'h0064 * c[i]);
			check(second_linear_code_reserved, c[i] > 5'h19);
		end
	endtask
	// Write, then a foreign address must be ignored on read back
	task test_regs;
		write(8'h0c, 8'h35);
		i_serial_host.write_reg(7'h61, 8'h0c, 8'h00, acks);
		check(acks, 3'h0);
		i_serial_host.read_reg(8'h0c, rd);
		check(rd, 8'h35);
	endtask
	task test_delays;
		write(8'h0c, 8'hf0);
		write(8'h0d, 8'h13);
		write(8'h0e, 8'h0f);
		write(8'h21, 8'h02);
		write(8'h20, 8'h3f); // Every code set before the pin moves
		measure(1'b1);
		check(t[0], 1);
		check(t[1], 3 * S + 2);
		check(t[2], 15 * S + 2);
		measure(1'b0);
		check(t[0], 15 * 2 * S + 2);
		check(t[1], 2 * S + 2);
		check(t[2], 1);
		write(8'h21, 8'h01);
		measure(1'b1);
		check(t[1], 3 * 2 * S + 2);
		check(t[2], 15 * 2 * S + 2);
		write(8'h21, 8'h00);
		measure(1'b0);
		check(t[0], 15 * S + 2);
		check(t[1], S + 2);
	endtask
	// Pin drops before the pending start expires, then a rail freed from the pin
	task test_cancel;
		int highs;
		highs = 0;
		@(negedge clk);
		enable_pin = 1'b1;
		repeat (2 * S) @(negedge clk);
		enable_pin = 1'b0;
		repeat (5 * S) begin
			@(negedge clk);
			if (second_buck_on !== 1'b0) highs++;
		end
		check(highs, 0);
		write(8'h20, 8'h10);
		repeat (3) @(negedge clk);
		check({first_buck_on, second_buck_on, first_linear_on}, 3'h1);
		// Status: only the freed linear rail on, all pin states idle, pin low
		i_serial_host.read_reg(8'h22, rd);
		check(rd, 8'h04);
	endtask
	task stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(negedge clk);
		test_reset;
		test_vset;
		test_regs;
		test_delays;
		test_cancel;
		stop_test;
	end
	// Run needs about a seventh of this span
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		stop_test;
	end
endmodule
